// file: include/rtc_consts.svh
// Register offsets, field positions and timing counts of the clock register map
`ifndef RTC_CONSTS_SVH
`define RTC_CONSTS_SVH

`define RTC_OFS_SEC       7'h00
`define RTC_OFS_ALM_SEC   7'h01
`define RTC_OFS_MIN       7'h02
`define RTC_OFS_ALM_MIN   7'h03
`define RTC_OFS_HOUR      7'h04
`define RTC_OFS_ALM_HOUR  7'h05
`define RTC_OFS_DOW       7'h06
`define RTC_OFS_DATE      7'h07
`define RTC_OFS_MONTH     7'h08
`define RTC_OFS_YEAR      7'h09
`define RTC_OFS_CTRL_A    7'h0a
`define RTC_OFS_CTRL_B    7'h0b
`define RTC_OFS_FLAGS     7'h0c
`define RTC_OFS_BATT      7'h0d
`define RTC_RAM_FIRST     7'h0e
`define RTC_RAM_LAST      7'h7f

// Control register B bit positions
`define RTC_B_FREEZE      7
`define RTC_B_PER_IE      6
`define RTC_B_ALM_IE      5
`define RTC_B_UPD_IE      4
`define RTC_B_SQ_EN       3
`define RTC_B_FMT         2
`define RTC_B_H24         1
`define RTC_B_SUMMER      0

// Reset values and codes of control fields
`define RTC_A_RESET       7'h00
`define RTC_B_RESET       8'h00
`define RTC_OSC_KEEP_TIME 3'h2
`define RTC_RATE_OFF      4'hf

// Timebase and update timing
`define RTC_SYS_HZ        26'h262_5a00
`define RTC_OSC_HZ        26'h000_8000
`define RTC_PEND_LEAD_NS  64'h0000_0000_0003_b920
`define RTC_PEND_LEAD_TICKS 15'((`RTC_PEND_LEAD_NS * 64'h8000 + 64'h3b9a_c9ff) / 64'h3b9a_ca00)
`define RTC_FIRST_UPD_MS  32'h0000_01f4
`define RTC_FIRST_UPD_TICKS 16'((`RTC_FIRST_UPD_MS * 32'h0000_8000) / 32'h0000_03e8)

`endif

// file: include/rtc_pkg.sv
// Types shared by the clock register map modules
package rtc_pkg;

    typedef struct packed {
        logic       wrEn;
        logic       rdEn;
        logic [6:0] addr;
        logic [7:0] data;
    } rtc_bus_req_type;

    typedef struct packed {
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hour;
        logic [7:0] dow;
        logic [7:0] date;
        logic [7:0] month;
        logic [7:0] year;
    } rtc_time_type;

endpackage

// file: sim/rtc_host_model.sv
// Host-side model issuing byte reads and writes on the register bus
`timescale 1ns/1ps
`default_nettype none

module rtc_host_model (
    input  wire logic                   sys_clk,
    input  wire logic [7:0]             busRdData,
    input  wire logic                   busRdValid,
    output var rtc_pkg::rtc_bus_req_type busReq
);
    initial busReq = '0;

    ////////////////////////////////////////////////////////////////////////
    // Called in the step of a rising edge; strobe lasts one cycle
    task automatic wr(input logic [6:0] a, input logic [7:0] dat);
        busReq <= '{1'b1, 1'b0, a, dat};
        @(posedge sys_clk);
        busReq <= '0;
        @(posedge sys_clk);
    endtask

    // Answer is registered, so it is sampled one edge after the take
    task automatic rd(input logic [6:0] a, output logic [7:0] dat, output logic vld);
        busReq <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge sys_clk);
        busReq <= '0;
        @(posedge sys_clk);
        vld = busRdValid;
        dat = busRdData;
    endtask
endmodule // rtc_host_model

`default_nettype wire

// file: sim/rtc_register_map_sva.sv
// Port-level assertions for the clock register map
`timescale 1ns/1ps
`default_nettype none

module rtc_register_map_sva (
    input wire logic                     sys_clk,
    input wire logic                     rst_n,
    input wire rtc_pkg::rtc_bus_req_type busReq,
    input wire logic                     resetPin_n,
    input wire logic                     backupValid,
    input wire logic [7:0]               busRdData,
    input wire logic                     busRdValid,
    input wire logic                     irqOut_n,
    input wire logic                     squareWaveOut
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence rdAt(logic [6:0] a);
        busReq.rdEn && busReq.addr == a;
    endsequence

    // Pin must be low across two edges before outputs settle
    sequence pinHeld;
        !resetPin_n [*2];
    endsequence

    ////////////////////////////////////////////////////////////////////////
    AST_RD_ANSWER: assert property (busReq.rdEn |=> busRdValid)
        else $error("read strobe not answered");
    AST_RD_PULSE: assert property (!busReq.rdEn |=> !busRdValid)
        else $error("read valid without strobe");
    AST_RD_HOLD: assert property (!busReq.rdEn |=> $stable(busRdData))
        else $error("read data moved without a read");
    AST_SYNC_RESET: assert property (disable iff (1'b0)
        !rst_n |=> busRdData == 8'h00 && !busRdValid && irqOut_n && !squareWaveOut)
        else $error("outputs not cleared by reset");
    AST_FLAGS_LOW: assert property (rdAt(7'h0c) |=> busRdData[3:0] == 4'h0)
        else $error("flag byte low nibble not zero");
    AST_BATT: assert property (rdAt(7'h0d) |=> busRdData == {$past(backupValid), 7'h00})
        else $error("battery byte wrong");
    AST_SEC_MSB: assert property (rdAt(7'h00) |=> !busRdData[7])
        else $error("seconds top bit set");
    AST_PIN_SQW: assert property (pinHeld |=> !squareWaveOut)
        else $error("square wave runs under reset pin");
    AST_PIN_IRQ: assert property (pinHeld |=> irqOut_n)
        else $error("interrupt active under reset pin");
endmodule // rtc_register_map_sva

bind rtc_register_map rtc_register_map_sva chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .busReq(busReq), .resetPin_n(resetPin_n),
    .backupValid(backupValid), .busRdData(busRdData), .busRdValid(busRdValid),
    .irqOut_n(irqOut_n), .squareWaveOut(squareWaveOut));

`default_nettype wire

// file: sim/rtc_register_map_test.sv
// Self-checking bench for the clock register map
`timescale 1ns/1ps
`default_nettype none

module rtc_register_map_test;
    logic                     sys_clk = 1'b0;
    logic                     rst_n = 1'b0;
    logic                     resetPin_n = 1'b1;
    logic                     backupValid = 1'b1;
    rtc_pkg::rtc_bus_req_type busReq;
    logic [7:0]               busRdData;
    logic                     busRdValid;
    logic                     irqOut_n;
    logic                     squareWaveOut;
    int                       failures = 0;
    int                       checks = 0;
    int                       cyc = 0;
    int                       n;
    logic [31:0]              seed = 32'h0000_85c0;
    logic [7:0]               mem [128];
    logic [7:0]               d;
    logic [7:0]               b;
    logic                     v;
    logic                     sq;
    logic                     low;
    logic                     run;
    logic [7:0]               aTab [12] = '{8'h03, 8'h13, 8'h33, 8'h43, 8'h53, 8'h63,
                                            8'h73, 8'h20, 8'h21, 8'h22, 8'h2f, 8'h23};

    rtc_register_map uut (.sys_clk(sys_clk), .rst_n(rst_n), .busReq(busReq),
        .resetPin_n(resetPin_n), .backupValid(backupValid), .busRdData(busRdData),
        .busRdValid(busRdValid), .irqOut_n(irqOut_n), .squareWaveOut(squareWaveOut));
    rtc_host_model host (.sys_clk(sys_clk), .busRdData(busRdData),
        .busRdValid(busRdValid), .busReq(busReq));

    always #12.5 sys_clk = ~sys_clk;

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction

    // Freeze write drops the update interrupt enable
    function automatic logic [7:0] expB(input logic [7:0] x);
        return x[7] ? (x & 8'hef) : x;
    endfunction

    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chkb(input string nm, input logic e, input logic g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic rdc(input string nm, input logic [6:0] a, input logic [7:0] e);
        host.rd(a, d, v);
        chkb("valid", 1'b1, v);
        chk8(nm, e, d);
    endtask

    task automatic test_done;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Sweep needs about 61000 cycles
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 75000) begin
            failures++;
            test_done;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        rdc("ctrlA", 7'h0a, 8'h00);
        rdc("ctrlB", 7'h0b, 8'h00);
        rdc("flags", 7'h0c, 8'h00);
        $display("test reset finished");
        // Oscillator stopped, so stray ones must survive until read back
        for (int i = 0; i < 128; i++) begin
            mem[i] = rnd();
            if (i < 10 || i > 13) host.wr(7'(i), mem[i]);
        end
        rdc("seconds", 7'h00, mem[0] & 8'h7f);
        for (int i = 1; i < 128; i++) begin
            if (i < 10 || i > 13) rdc("byte", 7'(i), mem[i]);
        end
        // Legal time byte and a don't-care alarm byte
        host.wr(7'h00, 8'h59);
        host.wr(7'h05, 8'hc0);
        rdc("seconds", 7'h00, 8'h59);
        rdc("hourAlarm", 7'h05, 8'hc0);
        host.wr(7'h0c, 8'hff);
        host.wr(7'h0d, 8'hff);
        rdc("flags", 7'h0c, 8'h00);
        backupValid <= 1'b0;
        rdc("batt", 7'h0d, 8'h00);
        backupValid <= 1'b1;
        rdc("batt", 7'h0d, 8'h80);
        host.wr(7'h0a, 8'hff);
        rdc("ctrlA", 7'h0a, 8'h7f);
        for (int i = 0; i < 8; i++) begin
            b = (i == 0) ? 8'h90 : rnd();
            host.wr(7'h0b, b);
            rdc("ctrlB", 7'h0b, expB(b));
        end
        $display("test access finished");
        host.wr(7'h0b, 8'h48);
        foreach (aTab[j]) begin
            host.wr(7'h0a, aTab[j]);
            host.rd(7'h0c, d, v);
            n = 0;
            low = 1'b0;
            sq = squareWaveOut;
            repeat (5000) begin
                @(posedge sys_clk);
                if (squareWaveOut !== sq) n++;
                sq = squareWaveOut;
                if (irqOut_n === 1'b0) low = 1'b1;
            end
            run = (aTab[j] == 8'h23);
            rdc("flags", 7'h0c, run ? 8'hc0 : 8'h00);
            chkb("toggling", run, n > 0);
            chkb("irq seen", run, low);
        end
        // Slowest tap (bit 13) first, so no periodic edge lands between the two reads
        host.wr(7'h0a, 8'h2f);
        host.rd(7'h0c, d, v);
        rdc("flags", 7'h0c, 8'h00);
        $display("test rates finished");
        host.wr(7'h0b, 8'h7f);
        resetPin_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        resetPin_n <= 1'b1;
        @(posedge sys_clk);
        rdc("ctrlB", 7'h0b, 8'h07);
        rdc("ctrlA", 7'h0a, 8'h2f);
        $display("test pin finished");
        test_done;
    end
endmodule // rtc_register_map_test

`default_nettype wire

// file: src/rtc_div_chain.sv
// Fifteen-stage count-up chain, periodic tap select and update window
`timescale 1ns/1ps
`default_nettype none
`include "rtc_consts.svh"

module rtc_div_chain #(
    parameter logic [63:0] RATE_TAPS = 64'hdcba_9876_5432_1fff
) (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       oscTick,
    input  wire logic [2:0] oscCtrl,
    input  wire logic       preload,
    input  wire logic [3:0] rateSel,
    output logic            secTick,
    output logic            pendWindow,
    output logic            tapLevel,
    output logic            tapEdge
);

    logic [14:0] cnt_r;
    logic        tapPrev_r;
    logic        run;
    logic        hold;
    logic [3:0]  tapIdx;

    assign run  = (oscCtrl == `RTC_OSC_KEEP_TIME);
    assign hold = (oscCtrl[2:1] == 2'b11);

    // Preload beats hold: in the write cycle hold still shows the old code
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cnt_r <= 15'h0000;
        end else if (preload) begin
            cnt_r <= 15'(16'h8000 - `RTC_FIRST_UPD_TICKS);
        end else if (hold) begin
            cnt_r <= 15'h0000;
        end else if (run && oscTick) begin
            cnt_r <= cnt_r + 15'h0001;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            secTick <= 1'b0;
        end else begin
            secTick <= run && oscTick && !preload && (cnt_r == 15'h7fff);
        end
    end

    // Last few timebase ticks before the wrap carry the update warning
    assign pendWindow = run && (cnt_r >= 15'h7fff - `RTC_PEND_LEAD_TICKS + 15'h0001);

    assign tapIdx   = RATE_TAPS[{rateSel, 2'b00} +: 4];
    assign tapLevel = (tapIdx != `RTC_RATE_OFF) && cnt_r[tapIdx];

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            tapPrev_r <= 1'b0;
            tapEdge   <= 1'b0;
        end else begin
            tapPrev_r <= tapLevel;
            tapEdge   <= tapLevel && !tapPrev_r;
        end
    end

endmodule // rtc_div_chain
`default_nettype wire

// file: src/rtc_osc_tick.sv
// Fractional divider making the 32.768 kHz timebase enable from sys_clk
`timescale 1ns/1ps
`default_nettype none
`include "rtc_consts.svh"

module rtc_osc_tick (
    input  wire logic sys_clk,
    input  wire logic rst_n,
    output logic      oscTick
);

    logic [25:0] acc_r;
    logic [25:0] accSum;

    // Phase accumulator keeps the average rate exact with no drift
    assign accSum = acc_r + `RTC_OSC_HZ;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            acc_r   <= 26'h000_0000;
            oscTick <= 1'b0;
        end else if (accSum >= `RTC_SYS_HZ) begin
            acc_r   <= accSum - `RTC_SYS_HZ;
            oscTick <= 1'b1;
        end else begin
            acc_r   <= accSum;
            oscTick <= 1'b0;
        end
    end

endmodule // rtc_osc_tick
`default_nettype wire

// file: src/rtc_register_map.sv
// Clock register map: time, alarm, control, status and general RAM
// How it works
// - All 128 bytes host readable, all but flag and battery bytes writable
// - Flag and battery status bytes ignore writes
// - Update pending bit read-only; writes touch low seven
// - Seconds bit 7 always reads zero
// - Format 0 counts in packed decimal digits
// - Format 1 counts in plain binary
// - Time and RAM contents undefined at power-up
// - Stray ones in time bytes accepted, later overwritten
// - Control bytes accessible even during update
// - Pending bit leads every update by 244 us
// - Time bytes stable while pending bit is low
// - Pending bit ignores external reset pin
// - Freeze bit blocks updates, clears pending bit
// - Only oscillator code 010 keeps time
// - Codes 11x hold the divider chain cleared
// - First update 500 ms after writing 010
// - Rate code picks a tap or none
// - Tap drives square wave and periodic flag
// - Rate code survives external reset pin
// - Format bit 1 binary, 0 packed decimal
// - Hour bit 1 means 24-hour counting
// - Hour bit 7 marks afternoon in 12-hour mode
// - Flag read or reset pin clears flags
`timescale 1ns/1ps
`default_nettype none
`include "rtc_consts.svh"

module rtc_register_map #(
    parameter logic [63:0] RATE_TAPS = 64'hdcba_9876_5432_1fff
) (
    input  wire logic                     sys_clk,
    input  wire logic                     rst_n,
    input  wire rtc_pkg::rtc_bus_req_type busReq,
    input  wire logic                     resetPin_n,
    input  wire logic                     backupValid,
    output logic [7:0]                    busRdData,
    output logic                          busRdValid,
    output logic                          irqOut_n,
    output logic                          squareWaveOut
);

    ////////////////////////////////////////////////////////////////////////////
    // Storage

    rtc_pkg::rtc_time_type timeNow_r;
    rtc_pkg::rtc_time_type timeNxt;
    logic [7:0]  almSec_r;
    logic [7:0]  almMin_r;
    logic [7:0]  almHour_r;
    logic [6:0]  ctrlA_r;
    logic [7:0]  ctrlB_r;
    logic        pending_r;
    logic        periodicFlag_r;
    logic        alarmFlag_r;
    logic        updateFlag_r;
    logic [7:0]  nvRam [`RTC_RAM_FIRST:`RTC_RAM_LAST];

    logic        oscTick;
    logic        secTick;
    logic        pendWindow;
    logic        tapLevel;
    logic        tapEdge;
    logic        doUpdate;
    logic        alarmHit;
    logic        wrA;
    logic        wrB;
    logic        rdFlags;
    logic        startOsc;
    logic        irqSummary;
    logic        freeze;
    logic        fmtBin;
    logic        hour24;

    assign freeze = ctrlB_r[`RTC_B_FREEZE];
    assign fmtBin = ctrlB_r[`RTC_B_FMT];
    assign hour24 = ctrlB_r[`RTC_B_H24];

    ////////////////////////////////////////////////////////////////////////////
    // Format conversion and calendar arithmetic

    function automatic logic [7:0] toBin(input logic [7:0] v, input logic bin);
        return bin ? v : ({4'h0, v[7:4]} * 8'h0a) + {4'h0, v[3:0]};
    endfunction

    function automatic logic [7:0] fromBin(input logic [7:0] v, input logic bin);
        return bin ? v : {4'(v / 8'h0a), 4'(v % 8'h0a)};
    endfunction

    function automatic logic [7:0] monthDays(input logic [7:0] mo, input logic [7:0] yr);
        logic [7:0] d;
        d = 8'h1f;
        unique case (mo)
            8'h04, 8'h06, 8'h09, 8'h0b: d = 8'h1e;
            8'h02: d = (yr[1:0] == 2'b00) ? 8'h1d : 8'h1c;
            default: d = 8'h1f;
        endcase
        return d;
    endfunction

    // Stray bits above each field are dropped here, so an update rewrites them
    function automatic rtc_pkg::rtc_time_type nextTime(input rtc_pkg::rtc_time_type t,
                                                       input logic bin,
                                                       input logic h24);
        rtc_pkg::rtc_time_type n;
        logic [7:0] s;
        logic [7:0] m;
        logic [7:0] h;
        logic [7:0] dw;
        logic [7:0] dt;
        logic [7:0] mo;
        logic [7:0] yr;
        logic       pm;
        logic       dayRoll;
        n       = t;
        s       = toBin({1'b0, t.sec[6:0]}, bin);
        m       = toBin({1'b0, t.min[6:0]}, bin);
        h       = toBin({2'b00, t.hour[5:0]}, bin);
        dw      = {5'h00, t.dow[2:0]};
        dt      = toBin({2'b00, t.date[5:0]}, bin);
        mo      = toBin({3'h0, t.month[4:0]}, bin);
        yr      = toBin(t.year, bin);
        pm      = t.hour[7];
        dayRoll = 1'b0;
        if (s < 8'h3b) begin
            s = s + 8'h01;
        end else begin
            s = 8'h00;
            if (m < 8'h3b) begin
                m = m + 8'h01;
            end else begin
                m = 8'h00;
                if (h24) begin
                    dayRoll = (h >= 8'h17);
                    h       = dayRoll ? 8'h00 : h + 8'h01;
                end else if (h == 8'h0b) begin
                    h       = 8'h0c;
                    dayRoll = pm;
                    pm      = !pm;
                end else begin
                    h = (h >= 8'h0c) ? 8'h01 : h + 8'h01;
                end
            end
        end
        if (dayRoll) begin
            dw = (dw >= 8'h07) ? 8'h01 : dw + 8'h01;
            if (dt >= monthDays(mo, yr)) begin
                dt = 8'h01;
                if (mo >= 8'h0c) begin
                    mo = 8'h01;
                    yr = (yr >= 8'h63) ? 8'h00 : yr + 8'h01;
                end else begin
                    mo = mo + 8'h01;
                end
            end else begin
                dt = dt + 8'h01;
            end
        end
        n.sec   = fromBin(s, bin);
        n.min   = fromBin(m, bin);
        n.hour  = (h24 ? 8'h00 : {pm, 7'h00}) | fromBin(h, bin);
        n.dow   = dw;
        n.date  = fromBin(dt, bin);
        n.month = fromBin(mo, bin);
        n.year  = fromBin(yr, bin);
        return n;
    endfunction

    function automatic logic fieldMatch(input logic [7:0] alm, input logic [7:0] cur);
        return (alm[7:6] == 2'b11) || (alm == cur);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Timebase and divider chain

    rtc_osc_tick u_tick (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .oscTick (oscTick)
    );

    rtc_div_chain #(
        .RATE_TAPS (RATE_TAPS)
    ) u_div (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .oscTick   (oscTick),
        .oscCtrl   (ctrlA_r[6:4]),
        .preload   (startOsc),
        .rateSel   (ctrlA_r[3:0]),
        .secTick   (secTick),
        .pendWindow (pendWindow),
        .tapLevel  (tapLevel),
        .tapEdge   (tapEdge)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Access decode

    assign wrA      = busReq.wrEn && (busReq.addr == `RTC_OFS_CTRL_A);
    assign wrB      = busReq.wrEn && (busReq.addr == `RTC_OFS_CTRL_B);
    assign rdFlags  = busReq.rdEn && (busReq.addr == `RTC_OFS_FLAGS);
    // Restart the half-second phase only when timekeeping is switched on
    assign startOsc = wrA && (busReq.data[6:4] == `RTC_OSC_KEEP_TIME)
                      && (ctrlA_r[6:4] != `RTC_OSC_KEEP_TIME);
    assign doUpdate = secTick && !freeze;
    assign timeNxt  = nextTime(timeNow_r, fmtBin, hour24);
    assign alarmHit = fieldMatch(almSec_r, timeNxt.sec)
                      && fieldMatch(almMin_r, timeNxt.min)
                      && fieldMatch(almHour_r, timeNxt.hour);

    ////////////////////////////////////////////////////////////////////////////
    // Time bytes: advanced by update, host write lands last

    // No reset here: time bytes are undefined until software sets them
    always_ff @(posedge sys_clk) begin
        if (doUpdate) begin
            timeNow_r <= timeNxt;
        end
        if (busReq.wrEn) begin
            unique case (busReq.addr)
                `RTC_OFS_SEC:   timeNow_r.sec   <= {1'b0, busReq.data[6:0]};
                `RTC_OFS_MIN:   timeNow_r.min   <= busReq.data;
                `RTC_OFS_HOUR:  timeNow_r.hour  <= busReq.data;
                `RTC_OFS_DOW:   timeNow_r.dow   <= busReq.data;
                `RTC_OFS_DATE:  timeNow_r.date  <= busReq.data;
                `RTC_OFS_MONTH: timeNow_r.month <= busReq.data;
                `RTC_OFS_YEAR:  timeNow_r.year  <= busReq.data;
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (busReq.wrEn) begin
            unique case (busReq.addr)
                `RTC_OFS_ALM_SEC:  almSec_r  <= busReq.data;
                `RTC_OFS_ALM_MIN:  almMin_r  <= busReq.data;
                `RTC_OFS_ALM_HOUR: almHour_r <= busReq.data;
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (busReq.wrEn && (busReq.addr >= `RTC_RAM_FIRST)) begin
            nvRam[busReq.addr] <= busReq.data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control registers

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ctrlA_r <= `RTC_A_RESET;
        end else if (wrA) begin
            ctrlA_r <= busReq.data[6:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ctrlB_r <= `RTC_B_RESET;
        end else begin
            if (wrB) begin
                ctrlB_r <= busReq.data;
                if (busReq.data[`RTC_B_FREEZE]) begin
                    ctrlB_r[`RTC_B_UPD_IE] <= 1'b0;
                end
            end
            // Pin reset drops enables but keeps freeze, format and summer time
            if (!resetPin_n) begin
                ctrlB_r[`RTC_B_PER_IE] <= 1'b0;
                ctrlB_r[`RTC_B_ALM_IE] <= 1'b0;
                ctrlB_r[`RTC_B_UPD_IE] <= 1'b0;
                ctrlB_r[`RTC_B_SQ_EN]  <= 1'b0;
            end
        end
    end

    // Pending bit follows update timing and the freeze bit; the reset pin is not looked at
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pending_r <= 1'b0;
        end else if (wrB && busReq.data[`RTC_B_FREEZE]) begin
            pending_r <= 1'b0;
        end else begin
            pending_r <= pendWindow && !freeze;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status flags: an event in the clearing cycle survives

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            periodicFlag_r <= 1'b0;
            alarmFlag_r    <= 1'b0;
            updateFlag_r   <= 1'b0;
        end else begin
            if (rdFlags || !resetPin_n) begin
                periodicFlag_r <= 1'b0;
                alarmFlag_r    <= 1'b0;
                updateFlag_r   <= 1'b0;
            end
            if (tapEdge) begin
                periodicFlag_r <= 1'b1;
            end
            if (doUpdate) begin
                updateFlag_r <= 1'b1;
                if (alarmHit) begin
                    alarmFlag_r <= 1'b1;
                end
            end
        end
    end

    assign irqSummary = (periodicFlag_r && ctrlB_r[`RTC_B_PER_IE])
                        || (alarmFlag_r && ctrlB_r[`RTC_B_ALM_IE])
                        || (updateFlag_r && ctrlB_r[`RTC_B_UPD_IE]);

    ////////////////////////////////////////////////////////////////////////////
    // Pins

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            irqOut_n      <= 1'b1;
            squareWaveOut <= 1'b0;
        end else begin
            irqOut_n      <= !irqSummary;
            squareWaveOut <= ctrlB_r[`RTC_B_SQ_EN] && tapLevel;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port, one cycle latency

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            busRdData  <= 8'h00;
            busRdValid <= 1'b0;
        end else begin
            busRdValid <= busReq.rdEn;
            if (busReq.rdEn) begin
                unique case (busReq.addr)
                    `RTC_OFS_SEC:      busRdData <= {1'b0, timeNow_r.sec[6:0]};
                    `RTC_OFS_ALM_SEC:  busRdData <= almSec_r;
                    `RTC_OFS_MIN:      busRdData <= timeNow_r.min;
                    `RTC_OFS_ALM_MIN:  busRdData <= almMin_r;
                    `RTC_OFS_HOUR:     busRdData <= timeNow_r.hour;
                    `RTC_OFS_ALM_HOUR: busRdData <= almHour_r;
                    `RTC_OFS_DOW:      busRdData <= timeNow_r.dow;
                    `RTC_OFS_DATE:     busRdData <= timeNow_r.date;
                    `RTC_OFS_MONTH:    busRdData <= timeNow_r.month;
                    `RTC_OFS_YEAR:     busRdData <= timeNow_r.year;
                    `RTC_OFS_CTRL_A:   busRdData <= {pending_r, ctrlA_r};
                    `RTC_OFS_CTRL_B:   busRdData <= ctrlB_r;
                    `RTC_OFS_FLAGS:    busRdData <= {irqSummary, periodicFlag_r,
                                                     alarmFlag_r, updateFlag_r,
                                                     4'h0};
                    `RTC_OFS_BATT:     busRdData <= {backupValid, 7'h00};
                    default:           busRdData <= nvRam[busReq.addr];
                endcase
            end
        end
    end

endmodule // rtc_register_map
`default_nettype wire
